/* hdl/ssb_alu_flags.sv */
`default_nettype none
module ssb_alu_flags (
  input  wire logic          [7:0] operand_a,
  input  wire logic          [7:0] operand_b,
  input  wire logic          [7:0] result,
  input  wire ssb_pkg::ssb_op_t    op,
  input  wire logic                carry_in,
  output logic                     zero,
  output logic                     digit_carry,
  output logic                     carry,
  output logic                     affects_zero,
  output logic                     affects_arith,
  output logic                     affects_carry
);
  import ssb_pkg::*;
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic [7:0] addend;

  // Subtraction adds the two's complement, so carries read as inverted borrows.
  always_comb begin
    addend = (op == SSB_OP_SUB) ? (~operand_b) : operand_b;
    low_sum = {1'h0, operand_a[3:0]} + {1'h0, addend[3:0]} + {4'h0, (op == SSB_OP_SUB)}; // [RULE_12]
    full_sum = {1'h0, operand_a} + {1'h0, addend} + {8'h00, (op == SSB_OP_SUB)}; // [RULE_12]
    zero = (result == 8'h00); // [RULE_09]
    digit_carry = low_sum[4]; // [RULE_10]
    carry = full_sum[8]; // [RULE_11]
    if (op == SSB_OP_ROT_LEFT) begin
      carry = operand_a[7]; // [RULE_13]
    end else if (op == SSB_OP_ROT_RIGHT) begin
      carry = operand_a[0]; // [RULE_13]
    end
    if (op != SSB_OP_ROT_LEFT && op != SSB_OP_ROT_RIGHT && op != SSB_OP_ADD && op != SSB_OP_SUB) begin
      carry = carry_in;
    end
    affects_arith = (op == SSB_OP_ADD) || (op == SSB_OP_SUB);
    affects_carry = affects_arith || (op == SSB_OP_ROT_LEFT) || (op == SSB_OP_ROT_RIGHT);
    affects_zero = affects_arith || (op == SSB_OP_LOGIC) || (op == SSB_OP_CLEAR);
  end
endmodule
`default_nettype wire

/* hdl/ssb_status.sv */
// Design decisions made here: the address map and the strobed register port.
`include "ssb_defines.svh"
`default_nettype none
// Notes on behaviour
// [RULE_01] The status register accepts writes from any instruction as destination.
// [RULE_02] Flag-affecting instructions to status keep ALU flags, not written data.
// [RULE_03] Instruction writes never change timeout or power-down flags.
// [RULE_04] Clear aimed at status zeroes bank bits and sets zero flag.
// [RULE_05] Bit clear, bit set, swap and move change no flag.
// [RULE_06] Indirect bank bit is the top address bit for indirect accesses.
// [RULE_07] Direct bank bits choose one of four 128-byte banks.
// [RULE_08] Timeout flag set at power-up, watchdog clear, sleep; cleared on timeout.
// [RULE_09] Zero flag reflects whether the result is zero.
// [RULE_10] Digit carry is carry out of bit 3 on add and subtract.
// [RULE_11] Carry is carry out of bit 7 on add and subtract.
// [RULE_12] Subtraction adds two's complement, carries act as inverted borrows.
// [RULE_13] Rotates load carry with the bit shifted out.
// [RULE_14] Power-down flag set by power-up or watchdog clear, cleared by sleep.
// [RULE_15] Reset clears bank bits; timeout and power-down follow the reset cause. Here power-down is set to 1 whatever the cause.
module ssb_status (
  input  wire logic               MCLK,
  input  wire logic               SYS_RST,
  input  wire logic               CLK_EN,
  input  wire ssb_pkg::ssb_cause_t RESET_CAUSE,
  input  wire logic         [8:0] REG_ADDR,
  input  wire logic         [7:0] REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic              [7:0] REG_RDATA,
  input  wire ssb_pkg::ssb_op_t   ALU_OP,
  input  wire logic         [7:0] ALU_OPERAND_A,
  input  wire logic         [7:0] ALU_OPERAND_B,
  input  wire logic         [7:0] ALU_RESULT,
  input  wire logic               ALU_VALID,
  input  wire logic               WATCHDOG_CLEAR,
  input  wire logic               SLEEP_EXEC,
  input  wire logic               WATCHDOG_TIMEOUT,
  input  wire logic         [6:0] DIRECT_OFFSET,
  input  wire logic         [7:0] INDIRECT_POINTER,
  output logic              [8:0] DIRECT_ADDR,
  output logic              [8:0] INDIRECT_ADDR,
  output logic              [7:0] STATUS_VALUE,
  output logic                    CARRY_FLAG
);
  import ssb_pkg::*;

  ssb_state_t st_r;
  ssb_state_t st_nxt;
  logic       rst_seen_r;
  logic       zero_w;
  logic       dc_w;
  logic       carry_w;
  logic       aff_zero;
  logic       aff_arith;
  logic       aff_carry;
  logic       hit_wr;
  logic [7:0] wr_val;

  ssb_alu_flags u_flags (
    .operand_a     (ALU_OPERAND_A),
    .operand_b     (ALU_OPERAND_B),
    .result        (ALU_RESULT),
    .op            (ALU_OP),
    .carry_in      (st_r.status_r[`SSB_BIT_CARRY]),
    .zero          (zero_w),
    .digit_carry   (dc_w),
    .carry         (carry_w),
    .affects_zero  (aff_zero),
    .affects_arith (aff_arith),
    .affects_carry (aff_carry)
  );

  // Next-state logic; hardware reset events outrank instruction effects.
  always_comb begin
    st_nxt = st_r;
    hit_wr = REG_WR && (REG_ADDR == `SSB_REG_ADDR); // [RULE_01]
    wr_val = REG_WDATA;
    if (hit_wr) begin
      // Bits 7..5 take the data; bits 2:0 take it only when no flag-affecting instruction is valid.
      st_nxt.status_r[7:5] = wr_val[7:5]; // [RULE_01] [RULE_04]
      // Any flag-affecting instruction blocks the data write to all three flags at once.
      // Flags the instruction leaves alone then keep their old value, as a clear needs.
      if (!ALU_VALID || (!aff_zero && !aff_carry)) begin
        st_nxt.status_r[2:0] = wr_val[2:0]; // [RULE_05] [RULE_02]
      end
    end
    // ALU flags win over the data write.
    if (ALU_VALID) begin
      if (aff_zero) begin
        st_nxt.status_r[`SSB_BIT_ZERO] = zero_w; // [RULE_02] [RULE_04] [RULE_09]
      end
      if (aff_arith) begin
        st_nxt.status_r[`SSB_BIT_DIGIT_CARRY] = dc_w; // [RULE_02] [RULE_10]
      end
      if (aff_carry) begin
        st_nxt.status_r[`SSB_BIT_CARRY] = carry_w; // [RULE_02] [RULE_11] [RULE_13]
      end
    end
    // Reset-status flags move only on hardware events; timeout is last so it wins.
    if (WATCHDOG_CLEAR) begin
      st_nxt.status_r[`SSB_BIT_TIMEOUT] = 1'h1; // [RULE_08] [RULE_03]
      st_nxt.status_r[`SSB_BIT_POWER_DOWN] = 1'h1; // [RULE_14]
    end
    if (SLEEP_EXEC) begin
      st_nxt.status_r[`SSB_BIT_TIMEOUT] = 1'h1; // [RULE_08]
      st_nxt.status_r[`SSB_BIT_POWER_DOWN] = 1'h0; // [RULE_14]
    end
    if (WATCHDOG_TIMEOUT) begin
      st_nxt.status_r[`SSB_BIT_TIMEOUT] = 1'h0; // [RULE_08]
    end
    // The reset cause port is read at the first enabled edge after release, not during reset.
    if (!rst_seen_r) begin
      st_nxt.status_r[`SSB_BIT_TIMEOUT] = (RESET_CAUSE != SSB_CAUSE_WATCHDOG); // [RULE_15]
      st_nxt.status_r[`SSB_BIT_POWER_DOWN] = `SSB_RESET_POWER_DOWN; // [RULE_15]
    end
    st_nxt.rdata_r = (REG_RD && REG_ADDR == `SSB_REG_ADDR) ? st_nxt.status_r : 8'h00;
    if (REG_RD && REG_ADDR == `SSB_REG_ADDR) begin
      st_nxt.rdata_r = st_r.status_r;
    end
  end

  // State register; the arithmetic flags are cleared at reset only for determinism.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_r.status_r <= {`SSB_RESET_BANK, `SSB_RESET_TIMEOUT, `SSB_RESET_POWER_DOWN, 3'h0}; // [RULE_15]
      st_r.rdata_r <= 8'h00;
      rst_seen_r <= 1'h0;
    end else if (CLK_EN) begin
      rst_seen_r <= 1'h1;
      st_r <= st_nxt;
    end
  end

  // Bank select bits form the high address bits for data-memory accesses.
  always_comb begin
    DIRECT_ADDR = {st_r.status_r[`SSB_BIT_DIRECT_HI], st_r.status_r[`SSB_BIT_DIRECT_LO], DIRECT_OFFSET}; // [RULE_07]
    INDIRECT_ADDR = {st_r.status_r[`SSB_BIT_INDIRECT], INDIRECT_POINTER}; // [RULE_06]
  end

  assign REG_RDATA = st_r.rdata_r;
  assign STATUS_VALUE = st_r.status_r;
  assign CARRY_FLAG = st_r.status_r[`SSB_BIT_CARRY];

  AST_NO_WRITE_TO: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && rst_seen_r && !WATCHDOG_CLEAR && !SLEEP_EXEC && !WATCHDOG_TIMEOUT)
    |=> $stable(st_r.status_r[4:3])) // [RULE_03]
    else $error("Reset-status flags changed without a hardware event.");
  AST_TIMEOUT_CLR: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && rst_seen_r && WATCHDOG_TIMEOUT) |=> !STATUS_VALUE[4]) // [RULE_08]
    else $error("Watchdog timeout did not clear the timeout flag.");
  AST_SLEEP_PD: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && rst_seen_r && SLEEP_EXEC && !WATCHDOG_TIMEOUT) |=> STATUS_VALUE[4:3] == 2'h2) // [RULE_14]
    else $error("Sleep did not set timeout and clear power-down.");
  AST_CLEAR_STATUS: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && rst_seen_r && hit_wr && ALU_VALID && ALU_OP == SSB_OP_CLEAR && REG_WDATA == 8'h00)
    |=> (STATUS_VALUE[7:5] == 3'h0 && STATUS_VALUE[2] && STATUS_VALUE[1:0] == $past(st_r.status_r[1:0]))) // [RULE_04]
    else $error("Clear of status gave wrong value.");
  AST_ALU_WINS: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && ALU_VALID && ALU_OP == SSB_OP_ADD) |=> (STATUS_VALUE[2:0] == $past({zero_w, dc_w, carry_w}))) // [RULE_02]
    else $error("Add result flags not loaded.");
  AST_BITOP_KEEP: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && ALU_VALID && !hit_wr && (ALU_OP == SSB_OP_BIT_SET || ALU_OP == SSB_OP_SWAP))
    |=> $stable(STATUS_VALUE[2:0])) // [RULE_05]
    else $error("Flag-neutral instruction changed a flag.");
  AST_ROT_CARRY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && ALU_VALID && ALU_OP == SSB_OP_ROT_RIGHT) |=> CARRY_FLAG == $past(ALU_OPERAND_A[0])) // [RULE_13]
    else $error("Rotate right did not load carry from bit zero.");
  AST_SUB_BORROW: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && ALU_VALID && ALU_OP == SSB_OP_SUB) |=> CARRY_FLAG == ($past(ALU_OPERAND_A) >= $past(ALU_OPERAND_B))) // [RULE_12]
    else $error("Subtract carry is not inverted borrow.");
  AST_BANK_ADDR: assert property (@(posedge MCLK) disable iff (SYS_RST)
    DIRECT_ADDR[8:7] == STATUS_VALUE[6:5] && INDIRECT_ADDR[8] == STATUS_VALUE[7]) // [RULE_06] [RULE_07]
    else $error("Bank bits not driving the address.");

  // The first enabled edge after reset loads the timeout flag from the cause and sets power-down.
  AST_RESET_CAUSE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && !rst_seen_r) |=> STATUS_VALUE[4:3] == {$past(RESET_CAUSE) != SSB_CAUSE_WATCHDOG, 1'h1}) // [RULE_15]
    else $error("Reset cause not applied to the reset-status flags.");
  // Read data stand for one cycle only, so a stale value never looks like a fresh read.
  AST_READ_ONCE: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && !(REG_RD && REG_ADDR == `SSB_REG_ADDR)) |=> REG_RDATA == 8'h00) // [RULE_01]
    else $error("Read data held beyond its cycle.");
  // A lone watchdog clear restores both reset-status flags.
  AST_WDC_PD: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CLK_EN && rst_seen_r && WATCHDOG_CLEAR && !SLEEP_EXEC && !WATCHDOG_TIMEOUT) |=> STATUS_VALUE[4:3] == 2'h3) // [RULE_14]
    else $error("Watchdog clear did not set both reset-status flags.");
endmodule
`default_nettype wire

/* pkg/ssb_defines.svh */
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH
`define SSB_BIT_CARRY        0
`define SSB_BIT_DIGIT_CARRY  1
`define SSB_BIT_ZERO         2
`define SSB_BIT_POWER_DOWN   3
`define SSB_BIT_TIMEOUT      4
`define SSB_BIT_DIRECT_LO    5
`define SSB_BIT_DIRECT_HI    6
`define SSB_BIT_INDIRECT     7
`define SSB_REG_ADDR         9'h003
`define SSB_RESET_BANK       3'h0
`define SSB_RESET_TIMEOUT    1'h1
`define SSB_RESET_POWER_DOWN 1'h1
`endif

/* pkg/ssb_pkg.sv */
`default_nettype none
package ssb_pkg;
  // Operation class presented by the core for the current instruction.
  typedef enum logic [3:0] {
    SSB_OP_NONE,
    SSB_OP_ADD,
    SSB_OP_SUB,
    SSB_OP_LOGIC,
    SSB_OP_CLEAR,
    SSB_OP_ROT_LEFT,
    SSB_OP_ROT_RIGHT,
    SSB_OP_BIT_CLEAR,
    SSB_OP_BIT_SET,
    SSB_OP_SWAP,
    SSB_OP_MOVE_W,
    SSB_OP_PLAIN
  } ssb_op_t;

  // Reset cause, which decides the timeout flag; power-down is set to 1 whatever the cause.
  typedef enum logic [1:0] {
    SSB_CAUSE_POWER_UP,
    SSB_CAUSE_EXTERNAL,
    SSB_CAUSE_WATCHDOG
  } ssb_cause_t;

  typedef struct packed {
    logic [7:0] status_r;
    logic [7:0] rdata_r;
  } ssb_state_t;
endpackage
`default_nettype wire

/* testbench/ssb_core_model.sv */
`default_nettype none
module ssb_core_model (
  input  wire logic                go,
  input  wire ssb_pkg::ssb_op_t    op,
  input  wire logic          [7:0] a,
  input  wire logic          [7:0] b,
  input  wire logic                cin,
  output var ssb_pkg::ssb_op_t     ALU_OP,
  output logic               [7:0] ALU_OPERAND_A,
  output logic               [7:0] ALU_OPERAND_B,
  output logic               [7:0] ALU_RESULT,
  output logic                     ALU_VALID
);
  import ssb_pkg::*;
  // The core shows an operation only while an instruction is in flight, so a stale op never reaches the flags.
  always_comb begin
    ALU_VALID = go;
    ALU_OP = go ? op : SSB_OP_NONE;
    ALU_OPERAND_A = a;
    ALU_OPERAND_B = b;
    case (op)
      SSB_OP_ADD:       ALU_RESULT = a + b;
      SSB_OP_SUB:       ALU_RESULT = a + ~b + 8'h01;
      SSB_OP_LOGIC:     ALU_RESULT = a & b;
      SSB_OP_CLEAR:     ALU_RESULT = 8'h00;
      SSB_OP_ROT_LEFT:  ALU_RESULT = {a[6:0], cin};
      SSB_OP_ROT_RIGHT: ALU_RESULT = {cin, a[7:1]};
      SSB_OP_SWAP:      ALU_RESULT = {a[3:0], a[7:4]};
      default:          ALU_RESULT = a;
    endcase
  end
endmodule
`default_nettype wire

/* testbench/status_flags_bank_select_tb.sv */
`default_nettype none
module status_flags_bank_select_tb import ssb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 0, SYS_RST = 1, CLK_EN = 1, REG_WR = 0, REG_RD = 0, go = 0, ALU_VALID, CARRY_FLAG;
  logic WATCHDOG_CLEAR, SLEEP_EXEC, WATCHDOG_TIMEOUT;
  logic [2:0] evt = 3'h0;
  logic [8:0] REG_ADDR = 9'h003, DIRECT_ADDR, INDIRECT_ADDR;
  logic [7:0] REG_WDATA = 8'h00, REG_RDATA, ALU_OPERAND_A, ALU_OPERAND_B, ALU_RESULT, STATUS_VALUE;
  logic [7:0] a = 8'h00, b = 8'h00, exp, INDIRECT_POINTER = 8'hA5;
  logic [6:0] DIRECT_OFFSET = 7'h5A;
  ssb_cause_t RESET_CAUSE = SSB_CAUSE_POWER_UP;
  ssb_op_t op = SSB_OP_NONE, ALU_OP;
  int err_count = 0, n_tests = 0;
  assign {WATCHDOG_CLEAR, SLEEP_EXEC, WATCHDOG_TIMEOUT} = evt;
  ssb_status u_dut (.MCLK, .SYS_RST, .CLK_EN, .RESET_CAUSE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .ALU_OP, .ALU_OPERAND_A, .ALU_OPERAND_B, .ALU_RESULT, .ALU_VALID, .WATCHDOG_CLEAR, .SLEEP_EXEC,
    .WATCHDOG_TIMEOUT, .DIRECT_OFFSET, .INDIRECT_POINTER, .DIRECT_ADDR, .INDIRECT_ADDR, .STATUS_VALUE, .CARRY_FLAG);
  ssb_core_model u_core (.go, .op, .a, .b, .cin(CARRY_FLAG), .ALU_OP, .ALU_OPERAND_A, .ALU_OPERAND_B,
    .ALU_RESULT, .ALU_VALID);
  // The 50 MHz core clock.
  initial forever #10 MCLK = ~MCLK;
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // Expected {zero, digit carry, carry}; a subtraction adds the inverted operand plus one.
  function automatic logic [2:0] aflags(input logic [7:0] x, input logic [7:0] y, input logic sub);
    logic [7:0] yb;
    logic [8:0] s;
    logic [4:0] n;
    yb = sub ? ~y : y;
    s = {1'b0, x} + {1'b0, yb} + {8'h00, sub};
    n = {1'b0, x[3:0]} + {1'b0, yb[3:0]} + {4'h0, sub};
    return {s[7:0] == 8'h00, n[4], s[8]};
  endfunction
  // One instruction slot: register write and core request share one edge; status is looked at after the next.
  task automatic slot(input logic wr, input logic [7:0] d, input logic v, input ssb_op_t o, input logic [7:0] x, y);
    @(posedge MCLK);
    REG_WR <= wr;
    REG_WDATA <= d;
    go <= v;
    op <= o;
    a <= x;
    b <= y;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    go <= 1'b0;
    op <= SSB_OP_NONE;
    #1;
  endtask
  // Writes, a read-back, an unmapped address and a frozen clock enable.
  task automatic t_write();
    slot(1'b1, 8'hE7, 1'b0, SSB_OP_NONE, 8'h00, 8'h00);
    chk(STATUS_VALUE, 8'hFF);
    slot(1'b1, 8'h00, 1'b0, SSB_OP_NONE, 8'h00, 8'h00);
    chk(STATUS_VALUE, 8'h18);
    REG_ADDR <= 9'h083;
    slot(1'b1, 8'hFF, 1'b0, SSB_OP_NONE, 8'h00, 8'h00);
    chk(STATUS_VALUE, 8'h18);
    REG_ADDR <= 9'h003;
    CLK_EN <= 1'b0;
    slot(1'b1, 8'hE7, 1'b0, SSB_OP_NONE, 8'h00, 8'h00);
    chk(STATUS_VALUE, 8'h18);
    CLK_EN <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, 8'h18);
    @(posedge MCLK);
    #1 chk(REG_RDATA, 8'h00);
  endtask
  // All bank codes, checked on both address outputs.
  task automatic t_banks();
    for (int i = 0; i < 8; i++) begin
      slot(1'b1, {i[2:0], 5'h00}, 1'b0, SSB_OP_NONE, 8'h00, 8'h00);
      chk(DIRECT_ADDR, {i[1:0], DIRECT_OFFSET});
      chk(INDIRECT_ADDR, {i[2], INDIRECT_POINTER});
    end
    exp = 8'hF8;
  endtask
  // Add and subtract at carry boundaries; every other case also writes status, which must lose bits 2:0.
  task automatic t_arith();
    ssb_op_t ops[6] = '{SSB_OP_ADD, SSB_OP_ADD, SSB_OP_ADD, SSB_OP_SUB, SSB_OP_SUB, SSB_OP_SUB};
    logic [7:0] xs[6] = '{8'h0F, 8'hFF, 8'h70, 8'h05, 8'h00, 8'h10};
    logic [7:0] ys[6] = '{8'h01, 8'h01, 8'h10, 8'h05, 8'h01, 8'h01};
    for (int i = 0; i < 6; i++) begin
      slot(i[0], 8'h27, 1'b1, ops[i], xs[i], ys[i]);
      exp[2:0] = aflags(xs[i], ys[i], ops[i] == SSB_OP_SUB);
      if (i[0]) exp[7:5] = 3'h1;
      chk(STATUS_VALUE, exp);
    end
  endtask
  // Rotates load carry from the bit shifted out; a logic op moves only zero; clear keeps 4:3 and 1:0.
  task automatic t_rot_clear();
    slot(1'b0, 8'h00, 1'b1, SSB_OP_ROT_LEFT, 8'h80, 8'h00);
    exp[0] = 1'b1;
    chk(STATUS_VALUE, exp);
    chk(CARRY_FLAG, 1'b1);
    slot(1'b0, 8'h00, 1'b1, SSB_OP_ROT_RIGHT, 8'h02, 8'h00);
    exp[0] = 1'b0;
    chk(STATUS_VALUE, exp);
    chk(CARRY_FLAG, 1'b0);
    slot(1'b0, 8'h00, 1'b1, SSB_OP_LOGIC, 8'hF0, 8'h0F);
    exp[2] = 1'b1;
    chk(STATUS_VALUE, exp);
    // Digit carry and carry set beforehand, so a clear that overwrote them would show.
    slot(1'b1, 8'hE3, 1'b0, SSB_OP_NONE, 8'h00, 8'h00);
    exp = 8'hFB;
    chk(STATUS_VALUE, exp);
    slot(1'b1, 8'h00, 1'b1, SSB_OP_CLEAR, 8'h5A, 8'h00);
    exp = {3'h0, exp[4:3], 1'b1, exp[1:0]};
    chk(STATUS_VALUE, exp);
  endtask
  // Bit clear, bit set, swap and move leave the written value in place, flags included.
  task automatic t_safe();
    ssb_op_t ops[4] = '{SSB_OP_BIT_CLEAR, SSB_OP_BIT_SET, SSB_OP_SWAP, SSB_OP_MOVE_W};
    logic [7:0] ds[4] = '{8'hA5, 8'h42, 8'hC7, 8'h00};
    for (int i = 0; i < 4; i++) begin
      slot(1'b1, ds[i], 1'b1, ops[i], 8'h00, 8'h00);
      exp = (ds[i] & 8'hE7) | 8'h18;
      chk(STATUS_VALUE, exp);
    end
  endtask
  // Hardware events on the two reset-status flags, in the order sleep, timeout, watchdog clear.
  task automatic ev(input logic [2:0] e, input logic [1:0] want);
    @(posedge MCLK);
    evt <= e;
    @(posedge MCLK);
    evt <= 3'h0;
    #1 chk(STATUS_VALUE[4:3], want);
  endtask
  // A mid-run reset caused by the watchdog must come back with the timeout flag low.
  task automatic t_reset();
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    RESET_CAUSE <= SSB_CAUSE_WATCHDOG;
    repeat (2) @(posedge MCLK);
    #1 chk(STATUS_VALUE, 8'h18);
    chk(REG_RDATA, 8'h00);
    @(posedge MCLK);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1 chk(STATUS_VALUE, 8'h08);
  endtask
  // A hang is cut short long after the sequence should have ended.
  initial begin
    #50000 err_count++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge MCLK);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1 chk(STATUS_VALUE, 8'h18);
    t_write();
    t_banks();
    t_arith();
    t_rot_clear();
    t_safe();
    ev(3'h2, 2'h2);
    ev(3'h1, 2'h0);
    ev(3'h4, 2'h3);
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
